// ---- fsq_pkg.sv ----
// Shared constants for the flash status and erase/write sequencer.
// Assumes a 10 MHz core clock and a flash part on an asynchronous parallel bus.
`default_nettype none
package fsq_pkg;
  localparam int CLK_MHZ     = 10;
  localparam int T_STROBE_NS = 300;
  // Least strobe width, rounded up to whole cycles
  localparam int STROBE_CYC  = (T_STROBE_NS * CLK_MHZ + 999) / 1000;

  localparam logic [7:0] REG_CTRL  = 8'h00;
  localparam logic [7:0] REG_ADDR  = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_STAT  = 8'h0C;
  localparam logic [7:0] REG_RDATA = 8'h10;

  localparam int CF_OP_LSB = 0;
  localparam int CF_ALT    = 3;
  localparam int CF_ARRAY  = 4;
  localparam int SF_BUSY    = 0;
  localparam int SF_RES_LSB = 1;
  localparam int SF_DEV_LSB = 8;
  localparam int SF_RB      = 16;

  localparam logic [7:0] CMD_READ_STATUS     = 8'h70;
  localparam logic [7:0] CMD_ERASE_SETUP     = 8'h20;
  localparam logic [7:0] CMD_CHIP_SETUP      = 8'h30;
  localparam logic [7:0] CMD_CONFIRM         = 8'hD0;
  localparam logic [7:0] CMD_WRITE_SETUP     = 8'h40;
  localparam logic [7:0] CMD_WRITE_SETUP_ALT = 8'h10;
  localparam logic [7:0] CMD_READ_ARRAY      = 8'hFF;

  localparam int SB_READY      = 7;
  localparam int SB_ERASE_FAIL = 5;
  localparam int SB_PROG_FAIL  = 4;
  localparam int SB_SUPPLY_LOW = 3;
  localparam int SB_PROTECT    = 1;

  typedef enum logic [2:0] {
    OP_NONE, OP_BLOCK_ERASE, OP_CHIP_ERASE, OP_WRITE,
    OP_CLEAR, OP_ARRAY, OP_STATUS, OP_IDENT
  } fsq_op_t;

  typedef enum logic [2:0] {
    RES_OK, RES_SUPPLY, RES_PROTECT, RES_SEQ, RES_FAIL
  } fsq_res_t;
endpackage
`default_nettype wire

// ---- fsq_cyc_if.sv ----
// Request/answer link between the sequencer and the flash bus cycle engine.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
`default_nettype none
interface fsq_cyc_if #(parameter int ADDR_W = 20, parameter int DQ_W = 16);
  logic              req;
  logic              wr;
  logic [ADDR_W-1:0] addr;
  logic [DQ_W-1:0]   wdata;
  logic              done;
  logic [DQ_W-1:0]   rdata;
  modport master (output req, wr, addr, wdata, input done, rdata);
  modport slave  (input req, wr, addr, wdata, output done, rdata);
endinterface
`default_nettype wire

// ---- fsq_cyc.sv ----
// Flash bus cycle engine: one read or write cycle per request.
// Assumes the flash is asynchronous; its data pins are synchronised here.
`timescale 1ns/1ps
`default_nettype none
module fsq_cyc import fsq_pkg::*; #(
  parameter int ADDR_W     = 20,
  parameter int DQ_W       = 16,
  parameter int STROBE_CYC = fsq_pkg::STROBE_CYC
) (
  input  wire logic              core_clk,
  input  wire logic              rst,
  fsq_cyc_if.slave               bus,
  output logic [ADDR_W-1:0]      fl_addr,
  output logic [DQ_W-1:0]        fl_dq_o,
  output logic                   fl_dq_oe_n,
  input  wire logic [DQ_W-1:0]   fl_dq_i,
  output logic                   fl_ce_n,
  output logic                   fl_oe_n,
  output logic                   fl_we_n
);
  typedef enum logic [1:0] {CY_IDLE = 2'b00, CY_SETUP = 2'b01, CY_STROBE = 2'b11,
                            CY_HOLD = 2'b10} fsq_cy_t;
  typedef struct packed {
    fsq_cy_t           st;
    logic [3:0]        cnt;
    logic              wr;
    logic              ce_n;
    logic              oe_n;
    logic              we_n;
    logic              dq_oe_n;
    logic [ADDR_W-1:0] addr;
    logic [DQ_W-1:0]   dq_o;
    logic [DQ_W-1:0]   s1;
    logic [DQ_W-1:0]   s2;
  } fsq_cyc_state_t;

  localparam fsq_cyc_state_t CYC_RESET = '{st: CY_IDLE, ce_n: 1'b1, oe_n: 1'b1,
                                           we_n: 1'b1, dq_oe_n: 1'b1, default: '0};
  fsq_cyc_state_t s_ff;
  fsq_cyc_state_t nxt_s;

  always_comb begin
    nxt_s    = s_ff;
    nxt_s.s1 = fl_dq_i;
    nxt_s.s2 = s_ff.s1;
    unique case (s_ff.st)
      CY_IDLE: begin
        if (bus.req) begin
          nxt_s.st      = CY_SETUP;
          nxt_s.wr      = bus.wr;
          nxt_s.addr    = bus.addr;
          nxt_s.dq_o    = bus.wdata;
          nxt_s.ce_n    = 1'b0;
          nxt_s.dq_oe_n = !bus.wr;
        end
      end
      CY_SETUP: begin
        nxt_s.st   = CY_STROBE;
        nxt_s.cnt  = 4'(STROBE_CYC - 1);
        nxt_s.we_n = !s_ff.wr;
        nxt_s.oe_n = s_ff.wr;
      end
      CY_STROBE: begin
        if (s_ff.cnt == 4'h0) begin
          nxt_s.st   = CY_HOLD;
          nxt_s.we_n = 1'b1;
        end else begin
          nxt_s.cnt = s_ff.cnt - 4'h1;
        end
      end
      CY_HOLD: begin
        // Output enable held through here so the synchronised data is settled
        nxt_s.st      = CY_IDLE;
        nxt_s.ce_n    = 1'b1;
        nxt_s.oe_n    = 1'b1;
        nxt_s.dq_oe_n = 1'b1;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_ff <= CYC_RESET;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign bus.done   = (s_ff.st == CY_HOLD);
  assign bus.rdata  = s_ff.s2;
  assign fl_addr    = s_ff.addr;
  assign fl_dq_o    = s_ff.dq_o;
  assign fl_dq_oe_n = s_ff.dq_oe_n;
  assign fl_ce_n    = s_ff.ce_n;
  assign fl_oe_n    = s_ff.oe_n;
  assign fl_we_n    = s_ff.we_n;
endmodule
`default_nettype wire

// ---- fsq_top.sv ----
// Host-side controller for a parallel flash: erase, write, status check.
// Assumes an APB master on core_clk and one flash part on the pins below.
`timescale 1ns/1ps
`default_nettype none
module fsq_top import fsq_pkg::*; #(
  parameter int         ADDR_W           = 20,
  parameter int         DQ_W             = 16,
  parameter int         STROBE_CYC       = fsq_pkg::STROBE_CYC,
  parameter logic [7:0] CMD_CLEAR_STATUS = 8'h50,
  parameter logic [7:0] CMD_READ_ID      = 8'h90
) (
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic [ADDR_W-1:0]      fl_addr,
  output logic [DQ_W-1:0]        fl_dq_o,
  output logic                   fl_dq_oe_n,
  input  wire logic [DQ_W-1:0]   fl_dq_i,
  output logic                   fl_ce_n,
  output logic                   fl_oe_n,
  output logic                   fl_we_n,
  input  wire logic              fl_ready_busy_n,
  output logic                   fl_reset_powerdown_n
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_PRE70 = 4'h1, ST_PREPOLL = 4'h3, ST_CMD1 = 4'h2,
    ST_CMD2 = 4'h6, ST_POLL = 4'h7, ST_CHECK = 4'h5, ST_CLR = 4'h4, ST_ARRAY = 4'hC
  } fsq_st_t;

  typedef struct packed {
    fsq_st_t           st;
    fsq_op_t           op;
    logic              alt;
    logic              arr;
    logic [ADDR_W-1:0] addr;
    logic [DQ_W-1:0]   wdata;
    logic [7:0]        stat;
    logic [DQ_W-1:0]   rdata;
    fsq_res_t          res;
    logic [31:0]       prdata;
    logic              rb_s1;
    logic              rb_s2;
    logic              rst_pd_n;
  } fsq_top_state_t;

  localparam fsq_top_state_t TOP_RESET = '{st: ST_IDLE, op: OP_NONE, res: RES_OK,
                                           default: '0};
  fsq_top_state_t s_ff;
  fsq_top_state_t nxt_s;

  fsq_cyc_if #(.ADDR_W(ADDR_W), .DQ_W(DQ_W)) cyc ();

  logic              c_req;
  logic              c_wr;
  logic [DQ_W-1:0]   c_wdata;

  function automatic logic is_prog_op(input fsq_op_t op);
    return (op == OP_BLOCK_ERASE) || (op == OP_CHIP_ERASE) || (op == OP_WRITE);
  endfunction

  function automatic logic [7:0] first_cmd(input fsq_op_t op, input logic alt);
    unique case (op)
      OP_BLOCK_ERASE: return CMD_ERASE_SETUP;
      OP_CHIP_ERASE:  return CMD_CHIP_SETUP;
      OP_WRITE:       return alt ? CMD_WRITE_SETUP_ALT : CMD_WRITE_SETUP;
      OP_CLEAR:       return CMD_CLEAR_STATUS;
      OP_ARRAY:       return CMD_READ_ARRAY;
      OP_STATUS:      return CMD_READ_STATUS;
      OP_IDENT:       return CMD_READ_ID;
      default:        return CMD_READ_STATUS;
    endcase
  endfunction

  // Bit 0 is never looked at; order decides which error is reported
  function automatic fsq_res_t full_check(input logic [7:0] flags, input fsq_op_t op);
    if (flags[SB_SUPPLY_LOW])                          return RES_SUPPLY;
    if (flags[SB_PROTECT])                             return RES_PROTECT;
    if (flags[SB_ERASE_FAIL] && flags[SB_PROG_FAIL])   return RES_SEQ;
    if (op == OP_WRITE ? flags[SB_PROG_FAIL] : flags[SB_ERASE_FAIL]) return RES_FAIL;
    return RES_OK;
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    return (a == REG_CTRL) || (a == REG_ADDR) || (a == REG_WDATA) ||
           (a == REG_STAT) || (a == REG_RDATA);
  endfunction

  always_comb begin
    nxt_s       = s_ff;
    nxt_s.rb_s1 = fl_ready_busy_n;
    nxt_s.rb_s2 = s_ff.rb_s1;
    nxt_s.rst_pd_n = 1'b1;
    c_req       = 1'b0;
    c_wr        = 1'b1;
    c_wdata     = DQ_W'(CMD_READ_STATUS);
    // Read data is latched in the setup phase so pready can stay high
    if (psel && !penable) begin
      unique case (paddr)
        REG_CTRL:  nxt_s.prdata = {27'h0, s_ff.arr, s_ff.alt, s_ff.op};
        REG_ADDR:  nxt_s.prdata = 32'(s_ff.addr);
        REG_WDATA: nxt_s.prdata = 32'(s_ff.wdata);
        REG_STAT:  nxt_s.prdata = {15'h0, s_ff.rb_s2, s_ff.stat, 4'h0, s_ff.res,
                                   s_ff.st != ST_IDLE};
        REG_RDATA: nxt_s.prdata = 32'(s_ff.rdata);
        default:   nxt_s.prdata = 32'h0;
      endcase
    end
    // Orders are taken only while idle so a running sequence never shifts
    if (psel && penable && pwrite && s_ff.st == ST_IDLE) begin
      unique case (paddr)
        REG_CTRL: begin
          nxt_s.op  = fsq_op_t'(pwdata[CF_OP_LSB +: 3]);
          nxt_s.alt = pwdata[CF_ALT];
          nxt_s.arr = pwdata[CF_ARRAY];
          nxt_s.res = RES_OK;
          if (nxt_s.op != OP_NONE) begin
            nxt_s.st = is_prog_op(nxt_s.op) ? ST_PRE70 : ST_CMD1;
          end
        end
        REG_ADDR:  nxt_s.addr  = pwdata[ADDR_W-1:0];
        REG_WDATA: nxt_s.wdata = pwdata[DQ_W-1:0];
        default: ;
      endcase
    end
    unique case (s_ff.st)
      ST_IDLE: ;
      ST_PRE70: begin
        c_req = 1'b1;
        if (cyc.done) nxt_s.st = ST_PREPOLL;
      end
      ST_PREPOLL: begin
        c_req = 1'b1;
        c_wr  = 1'b0;
        if (cyc.done && cyc.rdata[SB_READY]) nxt_s.st = ST_CMD1;
      end
      ST_CMD1: begin
        c_req   = 1'b1;
        c_wdata = DQ_W'(first_cmd(s_ff.op, s_ff.alt));
        if (cyc.done) begin
          unique case (s_ff.op)
            OP_CLEAR, OP_ARRAY: nxt_s.st = ST_IDLE;
            OP_STATUS:          nxt_s.st = ST_POLL;
            default:            nxt_s.st = ST_CMD2;
          endcase
        end
      end
      ST_CMD2: begin
        c_req   = 1'b1;
        c_wr    = (s_ff.op != OP_IDENT);
        c_wdata = (s_ff.op == OP_WRITE) ? s_ff.wdata : DQ_W'(CMD_CONFIRM);
        if (cyc.done) begin
          nxt_s.rdata = cyc.rdata;
          nxt_s.st    = (s_ff.op == OP_IDENT) ? ST_IDLE : ST_POLL;
        end
      end
      ST_POLL: begin
        c_req = 1'b1;
        c_wr  = 1'b0;
        if (cyc.done) begin
          nxt_s.rdata = cyc.rdata;
          // Flag bits taken only once ready reads 1
          if (cyc.rdata[SB_READY]) begin
            nxt_s.stat = cyc.rdata[7:0];
            nxt_s.st   = (s_ff.op == OP_STATUS) ? ST_IDLE : ST_CHECK;
          end
        end
      end
      ST_CHECK: begin
        nxt_s.res = full_check(s_ff.stat, s_ff.op);
        if (nxt_s.res != RES_OK) begin
          nxt_s.st = ST_CLR;
        end else begin
          nxt_s.st = s_ff.arr ? ST_ARRAY : ST_IDLE;
        end
      end
      ST_CLR: begin
        c_req   = 1'b1;
        c_wdata = DQ_W'(CMD_CLEAR_STATUS);
        if (cyc.done) nxt_s.st = s_ff.arr ? ST_ARRAY : ST_IDLE;
      end
      ST_ARRAY: begin
        c_req   = 1'b1;
        c_wdata = DQ_W'(CMD_READ_ARRAY);
        if (cyc.done) nxt_s.st = ST_IDLE;
      end
      default: nxt_s.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_ff <= TOP_RESET;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign cyc.req              = c_req;
  assign cyc.wr               = c_wr;
  assign cyc.addr             = s_ff.addr;
  assign cyc.wdata            = c_wdata;
  assign prdata               = s_ff.prdata;
  assign pready               = 1'b1;
  assign pslverr              = psel && penable && !is_mapped(paddr);
  assign fl_reset_powerdown_n = s_ff.rst_pd_n;

  fsq_cyc #(.ADDR_W(ADDR_W), .DQ_W(DQ_W), .STROBE_CYC(STROBE_CYC)) u_cyc (
    .core_clk   (core_clk),
    .rst        (rst),
    .bus        (cyc.slave),
    .fl_addr    (fl_addr),
    .fl_dq_o    (fl_dq_o),
    .fl_dq_oe_n (fl_dq_oe_n),
    .fl_dq_i    (fl_dq_i),
    .fl_ce_n    (fl_ce_n),
    .fl_oe_n    (fl_oe_n),
    .fl_we_n    (fl_we_n)
  );

  AST_MASK_RESERVED: assert property (@(posedge core_clk) disable iff (rst)
    s_ff.st == ST_CHECK && s_ff.stat[5:1] == 5'h0 |=> s_ff.res == RES_OK)
    else $error("reserved status bit affected result");
  AST_BUSY_IGNORED: assert property (@(posedge core_clk) disable iff (rst)
    s_ff.st == ST_POLL && cyc.done && !cyc.rdata[SB_READY]
    |=> s_ff.st == ST_POLL && $stable(s_ff.stat))
    else $error("status taken while busy");
  AST_PRE_POLL: assert property (@(posedge core_clk) disable iff (rst)
    $rose(s_ff.st == ST_CMD1) && is_prog_op(s_ff.op) |-> $past(s_ff.st) == ST_PREPOLL)
    else $error("command issued without ready poll");
  AST_ERASE_CONFIRM: assert property (@(posedge core_clk) disable iff (rst)
    s_ff.st == ST_CMD2 && s_ff.op == OP_BLOCK_ERASE
    |-> cyc.wr && cyc.wdata == DQ_W'(CMD_CONFIRM) && cyc.addr == s_ff.addr)
    else $error("block erase confirm wrong");
  AST_CHIP_SETUP: assert property (@(posedge core_clk) disable iff (rst)
    s_ff.st == ST_CMD1 && s_ff.op == OP_CHIP_ERASE ##1 s_ff.st == ST_CMD2
    |-> cyc.wdata == DQ_W'(CMD_CONFIRM) && $past(cyc.wdata) == DQ_W'(CMD_CHIP_SETUP))
    else $error("chip erase sequence wrong");
  AST_WRITE_SEQ: assert property (@(posedge core_clk) disable iff (rst)
    s_ff.st == ST_CMD2 && s_ff.op == OP_WRITE |-> cyc.wdata == s_ff.wdata && cyc.wr)
    else $error("write data cycle wrong");
  AST_CHECK_ORDER: assert property (@(posedge core_clk) disable iff (rst)
    s_ff.st == ST_CHECK && !s_ff.stat[SB_SUPPLY_LOW] && s_ff.stat[SB_PROTECT]
    |=> s_ff.res == RES_PROTECT)
    else $error("protect not reported after supply check");
  AST_CLEAR_ON_ERR: assert property (@(posedge core_clk) disable iff (rst)
    s_ff.st == ST_CHECK && s_ff.stat[SB_SUPPLY_LOW]
    |=> s_ff.st == ST_CLR && s_ff.res == RES_SUPPLY ##[1:40] s_ff.st != ST_CLR)
    else $error("error not followed by clear status");
  AST_ARRAY_LAST: assert property (@(posedge core_clk) disable iff (rst)
    s_ff.st == ST_ARRAY |-> cyc.wdata == DQ_W'(CMD_READ_ARRAY) && cyc.wr)
    else $error("array return command wrong");
endmodule
`default_nettype wire

// ---- fsq_flash_model.sv ----
// Behavioural flash part: status register, command decoder, identifier mode.
// Assumes the controller strobes writes by fl_we_n and reads by fl_oe_n.
`timescale 1ns/1ps
`default_nettype none
module fsq_flash_model import fsq_pkg::*; #(
  parameter logic [15:0] ID_CODE = 16'h005A,  // Arbitrary identifier code value
  parameter logic [7:0]  CLR_CMD = 8'h50,
  parameter logic [7:0]  ID_CMD  = 8'h90
) (
  input  wire logic [19:0] fl_addr,
  input  wire logic [15:0] fl_dq_o,
  input  wire logic        fl_dq_oe_n,
  output logic [15:0]      fl_dq_i,
  input  wire logic        fl_ce_n,
  input  wire logic        fl_oe_n,
  input  wire logic        fl_we_n,
  output logic             ready_busy_n,
  input  wire logic        reset_powerdown_n,
  input  wire logic        supply_low,
  input  wire logic        locked,
  input  wire logic        op_fail,
  input  wire logic        bad_seq,
  input  wire logic        res_bit,
  input  wire logic [3:0]  busy_reads
);
  logic [7:0]  sts;
  logic [7:0]  pend;
  logic [1:0]  mode;
  logic [15:0] last_q;
  logic [15:0] rd_val;
  int          rd_cnt;
  int          busy_until;
  logic [27:0] log_q[$];
  initial begin
    rd_cnt = 0;
    last_q = 16'h0000;
  end
  assign ready_busy_n = (rd_cnt >= busy_until);
  always_comb begin
    if (mode == 2'h1)
      // Bits 6..0 are junk while busy; suspend flags never set here
      rd_val = !ready_busy_n ? 16'h007F : {8'h00, 1'b1, sts[6:1], res_bit};
    else if (mode == 2'h2)
      rd_val = ID_CODE;
    else
      rd_val = 16'h1234;
  end
  // Released bus shows inverse of last value, never a stale copy
  assign fl_dq_i = !fl_dq_oe_n ? fl_dq_o : (!fl_ce_n && !fl_oe_n) ? rd_val : ~last_q;
  always @(posedge fl_oe_n) begin
    last_q = rd_val;
    if (mode == 2'h1)
      rd_cnt = rd_cnt + 1;
  end
  always @(posedge fl_we_n or negedge reset_powerdown_n) begin
    if (!reset_powerdown_n) begin
      sts = 8'h00;
      pend = 8'h00;
      mode = 2'h0;
      busy_until = 0;
    end else if (fl_ce_n === 1'b0) begin
      log_q.push_back({fl_addr, fl_dq_o[7:0]});
      if (pend != 8'h00) begin
        // Flags are ORed in, so they stay until clear status
        if ((pend == CMD_ERASE_SETUP || pend == CMD_CHIP_SETUP)
            && (fl_dq_o[7:0] != CMD_CONFIRM || bad_seq))
          sts[5:4] = 2'b11;
        else if (supply_low)
          sts[3] = 1'b1;
        else if (locked)
          sts[1] = 1'b1;
        else if (op_fail && pend inside {CMD_WRITE_SETUP, CMD_WRITE_SETUP_ALT})
          sts[4] = 1'b1;
        else if (op_fail)
          sts[5] = 1'b1;
        busy_until = rd_cnt + int'(busy_reads);
        mode = 2'h1;
        pend = 8'h00;
      end else begin
        case (fl_dq_o[7:0])
          CMD_READ_STATUS: mode = 2'h1;
          CMD_READ_ARRAY:  mode = 2'h0;
          ID_CMD:          mode = 2'h2;
          CLR_CMD:         sts = 8'h00;
          CMD_ERASE_SETUP, CMD_CHIP_SETUP, CMD_WRITE_SETUP, CMD_WRITE_SETUP_ALT:
            pend = fl_dq_o[7:0];
          default: ;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ---- fsq_top_tb.sv ----
// Self-checking bench for fsq_top driving the behavioural flash model.
// Assumes APB access through tasks and fault knobs on the model.
`timescale 1ns/1ps
`default_nettype none
module fsq_top_tb import fsq_pkg::*;;
  localparam logic [15:0] ID_VAL = 16'h005A;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        last_err;
  logic [19:0] fl_addr;
  logic [15:0] fl_dq_o;
  logic [15:0] fl_dq_i;
  logic        fl_dq_oe_n;
  logic        fl_ce_n;
  logic        fl_oe_n;
  logic        fl_we_n;
  logic        rb_n;
  logic        pd_n;
  logic        k_sup = 1'b0;
  logic        k_lock = 1'b0;
  logic        k_fail = 1'b0;
  logic        k_seq = 1'b0;
  int          bad_count = 0;
  int          num_checks = 0;
  int          cyc = 0;
  always #50 core_clk = ~core_clk;
  fsq_top fsq_top_i (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fl_addr(fl_addr), .fl_dq_o(fl_dq_o), .fl_dq_oe_n(fl_dq_oe_n),
    .fl_dq_i(fl_dq_i), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n),
    .fl_ready_busy_n(rb_n), .fl_reset_powerdown_n(pd_n));
  fsq_flash_model #(.ID_CODE(ID_VAL)) fsq_flash_model_i (.fl_addr(fl_addr),
    .fl_dq_o(fl_dq_o), .fl_dq_oe_n(fl_dq_oe_n), .fl_dq_i(fl_dq_i), .fl_ce_n(fl_ce_n),
    .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n), .ready_busy_n(rb_n), .reset_powerdown_n(pd_n),
    .supply_low(k_sup), .locked(k_lock), .op_fail(k_fail), .bad_seq(k_seq),
    .res_bit(1'b1), .busy_reads(4'h3));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      bad_count++;
      $display("[ERR] run_time expected done seen timeout");
      finish_test();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_idle(output logic [31:0] q);
    int k = 0;
    do begin
      apb(1'b0, REG_STAT, 32'h0, q);
      k++;
    end while (q[0] !== 1'b0 && k < 500);
    if (k >= 500) begin
      bad_count++;
      $display("[ERR] busy expected 0 seen 1");
    end
  endtask
  // Runs one op and checks result, device flags and the command trail
  task automatic do_op(input logic [4:0] ctrl, input logic [19:0] addr, input logic [2:0] res,
                       input logic [7:0] sts, input logic [39:0] seq, input int n,
                       input bit tgt);
    logic [31:0] q;
    fsq_flash_model_i.log_q.delete();
    apb(1'b1, REG_ADDR, {12'h000, addr}, q);
    apb(1'b1, REG_WDATA, 32'h0000_00A5, q);
    apb(1'b1, REG_CTRL, {27'h0, ctrl}, q);
    wait_idle(q);
    chk("result", {29'h0, res}, {29'h0, q[3:1]});
    if (sts[7])
      chk("dev_status", {25'h0, sts[7:1]}, {25'h0, q[15:9]});
    chk("log_len", 32'(n), 32'(fsq_flash_model_i.log_q.size()));
    for (int i = 0; i < n; i++)
      chk("cmd", {24'h0, seq[8*(n-1-i)+:8]}, {24'h0, fsq_flash_model_i.log_q[i][7:0]});
    if (tgt)
      chk("target_addr", {12'h0, addr}, {12'h0, fsq_flash_model_i.log_q[2][27:8]});
    $display("op %0d done", ctrl[2:0]);
  endtask
  task automatic s_errors();
    k_seq = 1'b1;
    do_op(5'h01, 20'h01000, 3'h3, 8'hB0, 40'h7020D050, 4, 1'b1);
    k_seq = 1'b0;
    k_fail = 1'b1;
    do_op(5'h01, 20'h02000, 3'h4, 8'hA0, 40'h7020D050, 4, 1'b1);
    do_op(5'h03, 20'h00055, 3'h4, 8'h90, 40'h7040A550, 4, 1'b1);
    k_fail = 1'b0;
    k_sup = 1'b1;
    do_op(5'h0B, 20'h00066, 3'h1, 8'h88, 40'h7010A550, 4, 1'b1);
    k_sup = 1'b0;
    k_lock = 1'b1;
    do_op(5'h12, 20'h00000, 3'h2, 8'h82, 40'h7030D050FF, 5, 1'b0);
    k_lock = 1'b0;
  endtask
  task automatic s_block_ok();
    logic [31:0] q;
    // Reserved bit reads 1 and busy polls show junk, neither may count
    do_op(5'h11, 20'h12345, 3'h0, 8'h80, 40'h7020D0FF, 4, 1'b1);
    apb(1'b0, REG_STAT, 32'h0, q);
    chk("ready_pin", 32'h1, {31'h0, q[16]});
  endtask
  task automatic s_single();
    logic [31:0] q;
    do_op(5'h04, 20'h0, 3'h0, 8'h00, 40'h50, 1, 1'b0);
    do_op(5'h05, 20'h0, 3'h0, 8'h00, 40'hFF, 1, 1'b0);
    do_op(5'h06, 20'h0, 3'h0, 8'h00, 40'h70, 1, 1'b0);
    do_op(5'h07, 20'h00002, 3'h0, 8'h00, 40'h90, 1, 1'b0);
    apb(1'b0, REG_RDATA, 32'h0, q);
    chk("ident", {16'h0, ID_VAL}, {16'h0, q[15:0]});
    apb(1'b0, 8'h20, 32'h0, q);
    chk("unmapped_err", 32'h1, {31'h0, last_err});
    chk("unmapped_data", 32'h0, q);
  endtask
  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    @(posedge core_clk);
    chk("reset_pin", 32'h1, {31'h0, pd_n});
    s_errors();
    s_block_ok();
    s_single();
    finish_test();
  end
endmodule
`default_nettype wire
